/* File: bench/cls_comm_loss_supervisor_tb.sv */
// Self-checking bench for the comm loss supervisor
`timescale 1ns/10ps
`default_nettype none
`include "cls_defines.svh"
module cls_comm_loss_supervisor_tb;
	import cls_pkg::*;
	// Stimulus and observation
	logic          ref_clk = 1'b0;
	logic          arst_n = 1'b0;
	logic [5:0]    avs_address = 6'h00;
	logic          avs_read = 1'b0;
	logic          avs_write = 1'b0;
	logic [31:0]   avs_writedata = 32'h0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic          bypass_mode = 1'b0;
	logic          irq;
	cls_msg_type   rx_msg;
	cls_drive_type drive;
	cls_ind_type   ind;
	int            fails = 0;
	int            checks_done = 0;
	logic [31:0]   rd;

	always #50 ref_clk = ~ref_clk;

	// Short tick so a 0.1 s unit is 20 cycles
	cls_comm_loss_supervisor #(.TICK_CYCLES(20), .RAMP_CYCLES(1)) uut (
		.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_msg(rx_msg), .bypass_mode(bypass_mode),
		.drive(drive), .ind(ind), .irq(irq));

	cls_net_master master (.ref_clk(ref_clk), .rx_msg(rx_msg));

	// ****************
	// Helpers
	// ****************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge ref_clk iff !avs_waitrequest);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	function automatic logic [31:0] cfg(input int en, input int sel, input int act,
			input int stp);
		return {25'h0, stp[1:0], act[2:0], sel[0], en[0]};
	endfunction
	// Configure, send one message, then stay silent well past the interval
	task automatic lose(input logic [31:0] c, input logic fwd, input logic [9:0] spd);
		bus(1'b1, `CLS_OFF_CTRL, c);
		master.send(fwd, 1'b0, spd);
		cyc(70);
	endtask
	task automatic back;
		master.send(1'b1, 1'b0, 10'd300);
		cyc(4);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		bus(1'b0, `CLS_OFF_CTRL, 32'h0);
		chk("ctrl", {25'h0, `CLS_RST_CTRL}, rd);
		bus(1'b0, `CLS_OFF_TIMEOUT, 32'h0);
		chk("timeout", {22'h0, `CLS_RST_TIMEOUT}, rd);
		bus(1'b0, `CLS_OFF_PRESET, 32'h0);
		chk("preset", {22'h0, `CLS_RST_PRESET}, rd);
		bus(1'b0, `CLS_OFF_DECEL, 32'h0);
		chk("decel", {`CLS_RST_DEC_FAST, `CLS_RST_DEC_NORM}, rd);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("drive", 32'h0, {9'h0, drive});
	endtask
	task automatic t_unarmed;
		bus(1'b1, `CLS_OFF_TIMEOUT, 32'h3);
		cyc(100);
		chk("ind_unarmed", 32'h0, {27'h0, ind});
	endtask
	task automatic t_refresh;
		repeat (5) begin
			master.send(1'b1, 1'b0, 10'd300);
			cyc(30);
		end
		chkb("alarm_refreshed", 1'b0, ind.comm_loss_alarm);
		cyc(35);
		chkb("alarm_late", 1'b1, ind.comm_loss_alarm);
		chk("speed_alarm", 32'd300, {22'h0, drive.speed_command});
		chkb("run_alarm", 1'b1, drive.run_forward_cmd);
		bus(1'b0, `CLS_OFF_SPEED, 32'h0);
		chk("speed_reg", {6'h0, 10'd300, 6'h0, 10'd300}, rd);
		back;
		chkb("alarm_resume", 1'b0, ind.comm_loss_alarm);
	endtask
	task automatic t_quiet;
		logic [31:0] cs[4];
		cs = '{cfg(1, 1, 4, 0), cfg(1, 1, 0, 0), cfg(1, 0, 1, 0), cfg(0, 1, 1, 0)};
		bus(1'b1, `CLS_OFF_PRESET, 32'd100);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `CLS_OFF_TIMEOUT, (i == 0) ? 32'h0 : 32'h3);
			lose(cs[i], 1'b1, 10'd300);
			chk("ind_quiet", 32'h0, {27'h0, ind});
			chk("speed_quiet", 32'd300, {22'h0, drive.speed_command});
			chkb("run_quiet", 1'b1, drive.run_forward_cmd);
		end
	endtask
	task automatic t_preset;
		lose(cfg(1, 1, 4, 0), 1'b1, 10'd300);
		chk("speed_preset", 32'd100, {22'h0, drive.speed_command});
		chkb("alarm_preset", 1'b1, ind.comm_loss_alarm);
		chkb("run_preset", 1'b1, drive.run_forward_cmd);
		back;
		lose(cfg(1, 1, 4, 0), 1'b0, 10'd300);
		chkb("run_stopped", 1'b0, drive.run_forward_cmd);
		back;
	endtask
	task automatic t_stop;
		int n;
		// Fast 1 and normal 2 sub steps per speed step with one cycle sub steps
		bus(1'b1, `CLS_OFF_DECEL, {16'd1, 16'd2});
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, `CLS_OFF_CTRL, cfg(1, 1, 3, m[1:0]));
			master.send(1'b1, 1'b0, 10'd300);
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (drive.speed_command !== 10'd0 && n < 100);
			chkb("loss_gap", 1'b1, n >= 38 && n < 80);
			n = 0;
			while (drive.output_freq !== 10'd0 && n < 700) begin
				cyc(1);
				n++;
			end
			// 300 speed steps from 30.0 Hz, each decel-time sub steps long
			if (m == 0) chkb("ramp_norm", 1'b1, n >= 598 && n <= 602);
			if (m == 2) chkb("ramp_fast", 1'b1, n >= 298 && n <= 302);
			if (m == 1) chkb("coast_time", 1'b1, n <= 2);
			chkb("coast", m == 1, drive.coast_stop);
			chkb("ext_fault", 1'b1, ind.external_option_fault);
			chkb("loss_fault", 1'b1, ind.comm_loss_fault);
			bus(1'b0, `CLS_OFF_STATUS, 32'h0);
			chk("status", (m == 1) ? 32'h45c : 32'h05c, rd);
			chkb("lamp_on", 1'b1, ind.fault_lamp);
			chkb("run_fault", 1'b0, drive.run_forward_cmd);
			back;
			chkb("lamp_off", 1'b0, ind.fault_lamp);
		end
	endtask
	task automatic t_bypass;
		@(posedge ref_clk);
		bypass_mode <= 1'b1;
		cyc(3);
		chkb("contactor_closed", 1'b1, ind.bypass_contactor);
		lose(cfg(1, 1, 3, 0), 1'b1, 10'd300);
		chkb("contactor_open", 1'b0, ind.bypass_contactor);
		chkb("bypass_coast", 1'b1, drive.coast_stop);
		back;
		lose(cfg(1, 1, 2, 1), 1'b1, 10'd300);
		chkb("fault_act2", 1'b1, ind.external_option_fault);
		chk("speed_act2", 32'h0, {22'h0, drive.speed_command});
		back;
		@(posedge ref_clk);
		bypass_mode <= 1'b0;
	endtask
	task automatic t_irq;
		bus(1'b1, `CLS_OFF_IRQ_CLR, 32'h3);
		bus(1'b1, `CLS_OFF_IRQ_EN, 32'h1);
		lose(cfg(1, 1, 1, 0), 1'b1, 10'd300);
		chkb("irq_loss", 1'b1, irq);
		bus(1'b0, `CLS_OFF_IRQ_STAT, 32'h0);
		chk("irq_stat_loss", 32'h1, rd);
		bus(1'b1, `CLS_OFF_IRQ_EN, 32'h0);
		cyc(2);
		chkb("irq_masked", 1'b0, irq);
		bus(1'b1, `CLS_OFF_IRQ_CLR, 32'h1);
		back;
		bus(1'b0, `CLS_OFF_IRQ_STAT, 32'h0);
		chk("irq_stat_resume", 32'h2, rd);
		bus(1'b1, `CLS_OFF_IRQ_EN, 32'h2);
		cyc(2);
		chkb("irq_resume", 1'b1, irq);
		bus(1'b1, `CLS_OFF_IRQ_CLR, 32'h2);
		cyc(2);
		chkb("irq_cleared", 1'b0, irq);
		bus(1'b0, `CLS_OFF_IRQ_CLR, 32'h0);
		chk("irq_clr_read", 32'h0, rd);
	endtask

	// ****************
	// Verdict and sequence
	// ****************
	task automatic finish_test;
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Whole run is a few thousand cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		fails++;
		finish_test;
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset;
		t_unarmed;
		t_refresh;
		t_quiet;
		t_preset;
		t_stop;
		t_bypass;
		t_irq;
		finish_test;
	end
endmodule
`default_nettype wire

/* File: bench/cls_net_master.sv */
// Network master model: sends one-cycle command messages to the supervisor
`timescale 1ns/10ps
`default_nettype none
module cls_net_master (
	// Clock
	input  wire logic            ref_clk,
	// Messages towards the supervisor
	output cls_pkg::cls_msg_type rx_msg
);
	import cls_pkg::*;

	initial rx_msg = '0;

	// One message, qualified by a single valid cycle
	task automatic send(input logic fwd, input logic rev, input logic [9:0] spd);
		@(posedge ref_clk);
		rx_msg <= '{valid: 1'b1, run_fwd: fwd, run_rev: rev, speed: spd};
		@(posedge ref_clk);
		// Fields are not held after valid, so show the inverse, never a stale copy
		rx_msg <= '{valid: 1'b0, run_fwd: !fwd, run_rev: !rev, speed: ~spd};
	endtask
endmodule
`default_nettype wire

/* File: rtl/cls_comm_loss_supervisor.sv */
// Comm loss supervisor: message gap watchdog, loss responses, register slave
//
// Functional notes
// - Declare loss when message gap exceeds interval, then apply selected response.
// - A zero interval disables loss detection completely.
// - With zero interval, preset speed and detect enable are ignored.
// - Keep-last-speed mode leaves run state and speed alone, no indication.
// - Action code 0 behaves like a zero interval.
// - Action 1 with detect enable raises the alarm, speed unchanged.
// - Action 4 loads preset speed into speed command if running, and raises alarm.
// - Stop-with-fault raises external fault and forces speed command to zero.
// - Stop method 0 ramps down using the normal decel time.
// - Stop method 1 coasts with no deceleration control.
// - Stop method 2 ramps down using the fast stop decel time.
// - Stop-with-fault action 3 in bypass mode opens contactor, motor coasts.
// - Timeout arms only after a first message since power-up.
// - Continue responses keep running only if a run command was active.
// - Fault lamp lights on timeout and stays lit until messages resume.
// - Detection select of 0 disables detection and ignores action code.
// - Action 3 also opens the bypass contactor.
`timescale 1ns/10ps
`default_nettype none
`include "cls_defines.svh"
module cls_comm_loss_supervisor #(
	parameter int TICK_CYCLES = `CLS_TICK_NS / `CLS_CLK_NS,
	parameter int RAMP_CYCLES = TICK_CYCLES / `CLS_FULL_SPEED
) (
	// Clock and reset
	input  wire logic           ref_clk,
	input  wire logic           arst_n,
	// Avalon-MM slave
	input  wire logic [5:0]     avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [31:0]    avs_writedata,
	output logic      [31:0]    avs_readdata,
	output logic                avs_waitrequest,
	// Network message and unit mode
	input  wire cls_pkg::cls_msg_type rx_msg,
	input  wire logic           bypass_mode,
	// Drive command and indications
	output cls_pkg::cls_drive_type    drive,
	output cls_pkg::cls_ind_type      ind,
	output logic                irq
);
	import cls_pkg::*;

	// ******************************
	// Registers and bus slave
	// ******************************
	logic [6:0]    cfg_ctrl;
	logic [9:0]    cfg_timeout;
	logic [9:0]    cfg_preset;
	logic [15:0]   cfg_dec_norm;
	logic [15:0]   cfg_dec_fast;
	logic [1:0]    irq_status;
	logic [1:0]    irq_enable;
	logic          ack;
	logic          wr_ok;
	logic [31:0]   next_rdata;
	logic [2:0]    act;
	logic [1:0]    stop_sel;
	cls_state_type state;
	cls_state_type next_state;
	logic [19:0]   cyc_cnt;
	logic [9:0]    tick_cnt;
	logic          tick;
	logic          msg;
	logic          lost;
	logic          lost_evt;
	logic          resume_evt;
	logic          detect_on;
	logic          fault_act;
	logic          running;
	logic          stopping;
	logic          ramp_fast;
	logic [19:0]   ramp_cyc;
	logic [15:0]   step_cnt;
	logic [15:0]   dec_lim;
	logic          sub_step;
	logic          step;
	cls_ind_type   next_ind;
	logic          cmd_fwd;
	logic          cmd_rev;
	logic          cmd_coast;
	logic [9:0]    cmd_speed;
	logic [9:0]    out_freq;

	assign act      = cfg_ctrl[`CLS_ACT_MSB:`CLS_ACT_LSB];
	assign stop_sel = cfg_ctrl[`CLS_STOP_MSB:`CLS_STOP_LSB];
	assign msg      = rx_msg.valid;
	assign lost     = (state == CLS_ST_LOST);
	assign running  = cmd_fwd | cmd_rev;

	// Drive bundle gathered from one register per concern, each with a single writer
	assign drive = '{run_forward_cmd: cmd_fwd, run_reverse_cmd: cmd_rev,
		coast_stop: cmd_coast, speed_command: cmd_speed, output_freq: out_freq};

	// One wait cycle per access; write lands when waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_ok           = avs_write & ack;

	// Access handshake
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_ctrl     <= `CLS_RST_CTRL;
			cfg_timeout  <= `CLS_RST_TIMEOUT;
			cfg_preset   <= `CLS_RST_PRESET;
			cfg_dec_norm <= `CLS_RST_DEC_NORM;
			cfg_dec_fast <= `CLS_RST_DEC_FAST;
			irq_enable   <= 2'h0;
		end else if (wr_ok) begin
			case (avs_address)
				`CLS_OFF_CTRL: begin
					cfg_ctrl <= avs_writedata[6:0];
				end
				`CLS_OFF_TIMEOUT: begin
					cfg_timeout <= avs_writedata[9:0];
				end
				`CLS_OFF_PRESET: begin
					cfg_preset <= avs_writedata[9:0];
				end
				`CLS_OFF_DECEL: begin
					cfg_dec_norm <= avs_writedata[15:0];
					cfg_dec_fast <= avs_writedata[31:16];
				end
				`CLS_OFF_IRQ_EN: begin
					irq_enable <= avs_writedata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (avs_address)
			`CLS_OFF_CTRL: begin
				next_rdata = {25'h0, cfg_ctrl};
			end
			`CLS_OFF_TIMEOUT: begin
				next_rdata = {22'h0, cfg_timeout};
			end
			`CLS_OFF_PRESET: begin
				next_rdata = {22'h0, cfg_preset};
			end
			`CLS_OFF_DECEL: begin
				next_rdata = {cfg_dec_fast, cfg_dec_norm};
			end
			`CLS_OFF_STATUS: begin
				next_rdata = {20'h0, bypass_mode, drive.coast_stop, drive.run_reverse_cmd,
					drive.run_forward_cmd, ind.bypass_contactor, ind.comm_loss_fault,
					ind.comm_loss_alarm, lost, state != CLS_ST_WAIT, stopping, 2'h0};
			end
			`CLS_OFF_SPEED: begin
				next_rdata = {6'h0, drive.output_freq, 6'h0, drive.speed_command};
			end
			`CLS_OFF_IRQ_STAT: begin
				next_rdata = {30'h0, irq_status};
			end
			`CLS_OFF_IRQ_EN: begin
				next_rdata = {30'h0, irq_enable};
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data captured on the waiting cycle, stands while waitrequest is low
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack) begin
			avs_readdata <= next_rdata;
		end
	end

	// ******************************
	// Interrupts
	// ******************************
	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_ok && avs_address == `CLS_OFF_IRQ_CLR && avs_writedata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (lost_evt) begin
				irq_status[`CLS_IRQ_LOST] <= 1'b1;
			end
			if (resume_evt) begin
				irq_status[`CLS_IRQ_RESUME] <= 1'b1;
			end
		end
	end

	// Level output
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ******************************
	// Message gap watchdog
	// ******************************
	// Detection needs a nonzero interval, both enables and a live action code
	assign detect_on = (cfg_timeout != 10'h000)
		& cfg_ctrl[`CLS_DET_EN] & cfg_ctrl[`CLS_DET_SEL]
		& (act != `CLS_ACT_IGNORE) & (act <= `CLS_ACT_PRESET);
	assign fault_act = (act == `CLS_ACT_FAULT) | (act == `CLS_ACT_OPEN);

	// Interval prescaler, restarted by every message so gaps are exact
	assign tick = (cyc_cnt == 20'(TICK_CYCLES - 1));
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_cnt  <= 20'h00000;
			tick_cnt <= 10'h000;
		end else if (msg || state != CLS_ST_WATCH) begin
			cyc_cnt  <= 20'h00000;
			tick_cnt <= 10'h000;
		end else if (tick) begin
			cyc_cnt <= 20'h00000;
			if (tick_cnt != 10'h3ff) begin
				tick_cnt <= tick_cnt + 10'h001;
			end
		end else begin
			cyc_cnt <= cyc_cnt + 20'h00001;
		end
	end

	// Watchdog state: unarmed until the first message
	always_comb begin
		next_state = state;
		case (state)
			CLS_ST_WAIT: begin
				if (msg) begin
					next_state = CLS_ST_WATCH;
				end
			end
			CLS_ST_WATCH: begin
				if (!msg && detect_on && tick_cnt >= cfg_timeout) begin
					next_state = CLS_ST_LOST;
				end
			end
			// Loss latches until traffic returns; config writes do not clear it
			CLS_ST_LOST: begin
				if (msg) begin
					next_state = CLS_ST_WATCH;
				end
			end
			default: begin
				next_state = CLS_ST_WAIT;
			end
		endcase
	end
	assign lost_evt   = (state == CLS_ST_WATCH) && (next_state == CLS_ST_LOST);
	assign resume_evt = lost && msg;

	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= CLS_ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// ******************************
	// Loss responses
	// ******************************
	// Indications follow the held loss state; the lamp clears only on resume
	always_comb begin
		next_ind                       = '0;
		next_ind.fault_lamp            = lost;
		next_ind.comm_loss_alarm       = lost & ((act == `CLS_ACT_ALARM)
			| (act == `CLS_ACT_PRESET));
		next_ind.comm_loss_fault       = lost & fault_act;
		next_ind.external_option_fault = lost & fault_act;
		next_ind.bypass_contactor      = bypass_mode
			& ~(lost & (act == `CLS_ACT_OPEN));
	end

	// Indication register; contactor starts open until the mode is seen
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ind <= '0;
		end else begin
			ind <= next_ind;
		end
	end

	// Run state and speed command; only messages ever start the motor
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_fwd   <= 1'b0;
			cmd_rev   <= 1'b0;
			cmd_speed <= 10'h000;
			cmd_coast <= 1'b0;
		end else if (msg) begin
			cmd_fwd   <= rx_msg.run_fwd;
			cmd_rev   <= rx_msg.run_rev;
			cmd_speed <= rx_msg.speed;
			cmd_coast <= 1'b0;
		end else if (lost_evt) begin
			case (act)
				`CLS_ACT_PRESET: begin
					if (running) begin
						cmd_speed <= cfg_preset;
					end
				end
				`CLS_ACT_FAULT, `CLS_ACT_OPEN: begin
					cmd_speed <= 10'h000;
					cmd_fwd   <= 1'b0;
					cmd_rev   <= 1'b0;
					// Open contactor in bypass leaves the motor coasting
					cmd_coast <= (stop_sel == `CLS_STOP_COAST)
						| ((act == `CLS_ACT_OPEN) & bypass_mode);
				end
				default: begin
				end
			endcase
		end
	end

	// Stop sequence flags; stopping held until messages resume, ramp_fast until the next fault loss
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stopping  <= 1'b0;
			ramp_fast <= 1'b0;
		end else if (msg) begin
			stopping <= 1'b0;
		end else if (lost_evt && fault_act) begin
			stopping  <= 1'b1;
			ramp_fast <= (stop_sel == `CLS_STOP_FAST);
		end
	end

	// ******************************
	// Deceleration ramp
	// ******************************
	// Decel time is full scale to zero; zero time is taken as one unit
	assign dec_lim  = ramp_fast ? cfg_dec_fast : cfg_dec_norm;
	assign sub_step = (ramp_cyc == 20'(RAMP_CYCLES - 1));
	assign step     = sub_step && (step_cnt + 16'h0001 >= dec_lim);

	// Step timing; the sub step rounds down so ramps run slightly short
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ramp_cyc <= 20'h00000;
			step_cnt <= 16'h0000;
		end else if (!stopping) begin
			ramp_cyc <= 20'h00000;
			step_cnt <= 16'h0000;
		end else if (sub_step) begin
			ramp_cyc <= 20'h00000;
			step_cnt <= step ? 16'h0000 : step_cnt + 16'h0001;
		end else begin
			ramp_cyc <= ramp_cyc + 20'h00001;
		end
	end

	// Output frequency tracks the command except while stopping
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_freq <= 10'h000;
		end else if (!stopping) begin
			out_freq <= cmd_speed;
		end else if (cmd_coast) begin
			out_freq <= 10'h000;
		end else if (step && out_freq != 10'h000) begin
			out_freq <= out_freq - 10'h001;
		end
	end

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_entry_fault;
		lost_evt && fault_act;
	endsequence
	sequence s_stopped_out;
		drive.speed_command == 10'h000 && !drive.run_forward_cmd && !drive.run_reverse_cmd;
	endsequence

	property p_unarmed;
		(state == CLS_ST_WAIT) |=> !ind.fault_lamp && !ind.comm_loss_alarm;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("loss shown before first message");
	property p_zero_off;
		(!lost && cfg_timeout == 10'h000) |=> !lost;
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("loss with zero interval");
	property p_sel_off;
		(!lost && (!cfg_ctrl[`CLS_DET_SEL] || act == `CLS_ACT_IGNORE)) |=> !lost;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("loss while detection off");
	property p_restart;
		msg |=> (state == CLS_ST_WATCH) && (tick_cnt == 10'h000) && (cyc_cnt == 20'h00000);
	endproperty
	a_restart: assert property (p_restart) else $error("message did not restart timer");
	property p_alarm_keep;
		(lost && act == `CLS_ACT_ALARM && !msg)
			|=> ind.comm_loss_alarm && $stable(drive.speed_command);
	endproperty
	a_alarm_keep: assert property (p_alarm_keep) else $error("alarm response wrong");
	property p_preset;
		(lost_evt && act == `CLS_ACT_PRESET && running)
			|=> drive.speed_command == $past(cfg_preset) ##1 ind.comm_loss_alarm;
	endproperty
	a_preset: assert property (p_preset) else $error("preset speed not applied");
	property p_no_restart;
		(lost_evt && !running) |=> !drive.run_forward_cmd && !drive.run_reverse_cmd;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("stopped drive restarted");
	property p_fault;
		s_entry_fault |=> s_stopped_out ##1 ind.external_option_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("fault response wrong");
	property p_contactor;
		(lost && act == `CLS_ACT_OPEN) |=> !ind.bypass_contactor;
	endproperty
	a_contactor: assert property (p_contactor) else $error("contactor not opened");
	property p_lamp;
		(lost && !msg) |=> ind.fault_lamp [*2];
	endproperty
	a_lamp: assert property (p_lamp) else $error("fault lamp not lit");
	property p_coast;
		(stopping && drive.coast_stop) |=> drive.output_freq == 10'h000;
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop left frequency");
	property p_ramp;
		(stopping && !drive.coast_stop && !msg && step && drive.output_freq != 10'h000)
			|=> drive.output_freq == $past(drive.output_freq) - 10'h001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp step wrong");

endmodule
`default_nettype wire

/* File: rtl/cls_defines.svh */
// Register map, field positions, reset values and timing of the comm loss supervisor
`ifndef CLS_DEFINES_SVH
`define CLS_DEFINES_SVH
// Byte offsets on the register bus
`define CLS_OFF_CTRL      6'h00
`define CLS_OFF_TIMEOUT   6'h04
`define CLS_OFF_PRESET    6'h08
`define CLS_OFF_DECEL     6'h0c
`define CLS_OFF_STATUS    6'h10
`define CLS_OFF_SPEED     6'h14
`define CLS_OFF_IRQ_STAT  6'h20
`define CLS_OFF_IRQ_CLR   6'h24
`define CLS_OFF_IRQ_EN    6'h28
// Control register fields
`define CLS_DET_EN        0
`define CLS_DET_SEL       1
`define CLS_ACT_LSB       2
`define CLS_ACT_MSB       4
`define CLS_STOP_LSB      5
`define CLS_STOP_MSB      6
// Reset values
`define CLS_RST_CTRL      7'h07
`define CLS_RST_TIMEOUT   10'h014
`define CLS_RST_PRESET    10'h000
`define CLS_RST_DEC_NORM  16'h0064
`define CLS_RST_DEC_FAST  16'h0032
// Action codes and stop methods
`define CLS_ACT_IGNORE    3'h0
`define CLS_ACT_ALARM     3'h1
`define CLS_ACT_FAULT     3'h2
`define CLS_ACT_OPEN      3'h3
`define CLS_ACT_PRESET    3'h4
`define CLS_STOP_RAMP     2'h0
`define CLS_STOP_COAST    2'h1
`define CLS_STOP_FAST     2'h2
// Interrupt bits
`define CLS_IRQ_LOST      0
`define CLS_IRQ_RESUME    1
// Timing: clock period and interval unit (0.1 s) in ns, full scale speed steps
`define CLS_CLK_NS        100
`define CLS_TICK_NS       100000000
`define CLS_FULL_SPEED    600
`endif

/* File: rtl/cls_pkg.sv */
// Types shared by the comm loss supervisor
package cls_pkg;
	typedef enum logic [2:0] {
		CLS_ST_WAIT  = 3'b001,
		CLS_ST_WATCH = 3'b010,
		CLS_ST_LOST  = 3'b100
	} cls_state_type;
	typedef struct packed {
		logic       valid;
		logic       run_fwd;
		logic       run_rev;
		logic [9:0] speed;
	} cls_msg_type;
	typedef struct packed {
		logic       run_forward_cmd;
		logic       run_reverse_cmd;
		logic       coast_stop;
		logic [9:0] speed_command;
		logic [9:0] output_freq;
	} cls_drive_type;
	typedef struct packed {
		logic comm_loss_alarm;
		logic comm_loss_fault;
		logic external_option_fault;
		logic fault_lamp;
		logic bypass_contactor;
	} cls_ind_type;
endpackage
